/* File: core/mbp_port_top.sv */
`timescale 1ns/100ps
// Functional notes
// - Serve up to eight user channels directly
// - Each channel owns a 2048-bit buffer
// - Control words kept in separate ninth buffer
// - Bus data goes to channel named earlier
// - Draining channel blocks other channels' interrupt only while it is addressed
// - Channel signals busy during user transfer
// - Busy addressed channel keeps inhibit raised
// - One central controller runs all bus transfers
// - Serial or parallel user output format per channel
// - Channels fitted individually; default two fitted
// - Inhibit active in reset and while addressed channel busy
// - CRC-8 checked; acknowledge only on good block
// - Poll after interrupt sends, else receives
// - Interrupt never asserted while inhibit asserted
module mbp_port_top import mbp_pkg::*; #(
	parameter logic [NUM_CH-1:0] CH_FITTED = CH_FITTED_INIT
) (
	// Clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// Bus master controller lines
	input wire logic bmc_poll,
	output logic bmc_inhibit,
	output logic bmc_ack,
	output logic bmc_intr,
	// Shared bus, word framed
	input wire mbp_bus_word_s bus_rx,
	output logic bus_tx_valid,
	output logic [WORD_W-1:0] bus_tx_data,
	// User channels, toward user
	output logic [NUM_CH-1:0] usr_out_valid,
	output logic [NUM_CH-1:0][WORD_W-1:0] usr_out_data,
	input wire logic [NUM_CH-1:0] usr_out_ready,
	// User channels, from user
	input wire logic [NUM_CH-1:0] usr_in_valid,
	input wire logic [NUM_CH-1:0][WORD_W-1:0] usr_in_data,
	input wire logic [NUM_CH-1:0] usr_in_last,
	output logic [NUM_CH-1:0] usr_in_ready,
	// Channel status
	output logic [NUM_CH-1:0] usr_busy,
	output logic [NUM_CH-1:0] usr_serial
);
	mbp_port_e state_reg;
	logic poll_q_reg;
	logic [CH_W-1:0] dest_reg;
	logic [CH_W-1:0] src_reg;
	logic [NUM_CH-1:0] fmt_reg;
	logic [CNT_W-1:0] rx_cnt_reg;
	logic [CNT_W-1:0] tx_ptr_reg;
	logic rx_accept_reg;
	logic iss_q_reg;
	logic [CRC_W-1:0] crc_reg;
	logic [ADDR_W-1:0] ctrl_ptr_reg;
	logic [NUM_CH-1:0] busy_meta_reg;
	logic [NUM_CH-1:0] busy_sync_reg;
	logic [NUM_CH-1:0] rx_good_reg;
	logic [NUM_CH-1:0] send_done_reg;
	logic ack_reg;
	logic inhibit_reg;
	logic intr_reg;
	logic tx_valid_reg;
	logic [WORD_W-1:0] tx_data_reg;

	logic [NUM_CH-1:0] ch_idle;
	logic [NUM_CH-1:0] ch_pend;
	logic [NUM_CH-1:0] usr_fire;
	logic [NUM_CH-1:0][WORD_W-1:0] ch_rdata;
	logic [NUM_CH-1:0][CNT_W-1:0] ch_cnt;
	logic poll_rise;
	logic rx_ctrl;
	logic rx_data;
	logic accept_now;
	logic rx_ok;
	logic tx_issue;
	logic inhibit_next;
	mbp_ctrl_word_s ctrl_word;

	function automatic logic [CH_W-1:0] lowest_set(input logic [NUM_CH-1:0] v);
		logic [CH_W-1:0] r;
		r = '0;
		for (int k = NUM_CH - 1; k >= 0; k--) begin
			if (v[k]) begin
				r = CH_W'(k);
			end
		end
		return r;
	endfunction

	assign poll_rise = bmc_poll && !poll_q_reg;
	assign ctrl_word = mbp_ctrl_word_s'(bus_rx.data);
	assign rx_ctrl = state_reg == P_RECV && bus_rx.valid && bus_rx.ctrl;
	assign rx_data = state_reg == P_RECV && bus_rx.valid && !bus_rx.ctrl;
	// First word decides; a user word taken that cycle wins the buffer
	assign accept_now = CH_FITTED[dest_reg] && ch_idle[dest_reg] &&
		!usr_fire[dest_reg];
	assign rx_ok = (rx_cnt_reg == '0) ? accept_now : rx_accept_reg;
	assign tx_issue = state_reg == P_SEND &&
		tx_ptr_reg < ch_cnt[src_reg];

	// Central bus sequencer
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			state_reg <= P_IDLE;
			rx_cnt_reg <= '0;
			tx_ptr_reg <= '0;
			rx_accept_reg <= 1'h0;
			iss_q_reg <= 1'h0;
			crc_reg <= CRC_INIT;
			src_reg <= '0;
			rx_good_reg <= '0;
			send_done_reg <= '0;
		end else begin
			rx_good_reg <= '0;
			send_done_reg <= '0;
			iss_q_reg <= tx_issue;
			unique case (state_reg)
				P_IDLE: begin
					if (poll_rise) begin
						crc_reg <= CRC_INIT;
						rx_cnt_reg <= '0;
						tx_ptr_reg <= '0;
						if (intr_reg) begin
							state_reg <= P_SEND;
							src_reg <= lowest_set(ch_pend);
						end else begin
							state_reg <= P_RECV;
						end
					end
				end
				P_RECV: begin
					if (rx_data) begin
						rx_cnt_reg <= rx_cnt_reg + CNT_W'(1);
						crc_reg <= mbp_crc8(crc_reg, bus_rx.data);
						rx_accept_reg <= rx_ok;
						if (rx_cnt_reg == FULL_CNT - CNT_W'(1)) begin
							state_reg <= P_CHECK;
						end
					end else if (!bmc_poll && rx_cnt_reg == '0) begin
						state_reg <= P_IDLE;
					end
				end
				P_CHECK: begin
					if (bus_rx.valid) begin
						state_reg <= P_IDLE;
						if (rx_accept_reg &&
							bus_rx.data[CRC_W-1:0] == crc_reg) begin
							rx_good_reg[dest_reg] <= 1'h1;
						end
					end
				end
				P_SEND: begin
					if (tx_issue) begin
						tx_ptr_reg <= tx_ptr_reg + CNT_W'(1);
					end
					if (iss_q_reg) begin
						crc_reg <= mbp_crc8(crc_reg, ch_rdata[src_reg]);
					end
					if (!tx_issue && !iss_q_reg) begin
						state_reg <= P_SCRC;
					end
				end
				P_SCRC: begin
					state_reg <= P_IDLE;
					send_done_reg[src_reg] <= 1'h1;
				end
				default: begin
					state_reg <= P_IDLE;
				end
			endcase
		end
	end

	// Outgoing bus words, CRC appended in its own word
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			tx_valid_reg <= 1'h0;
			tx_data_reg <= '0;
		end else if (state_reg == P_SEND) begin
			tx_valid_reg <= iss_q_reg;
			tx_data_reg <= ch_rdata[src_reg];
		end else if (state_reg == P_SCRC) begin
			tx_valid_reg <= 1'h1;
			tx_data_reg <= {{(WORD_W - CRC_W){1'h0}}, crc_reg};
		end else begin
			tx_valid_reg <= 1'h0;
		end
	end

	// Control word decode and storage
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			dest_reg <= '0;
			fmt_reg <= '0;
			ctrl_ptr_reg <= '0;
		end else if (rx_ctrl) begin
			ctrl_ptr_reg <= ctrl_ptr_reg + ADDR_W'(1);
			if (ctrl_word.cmd == CMD_SELECT) begin
				dest_reg <= ctrl_word.chan;
				fmt_reg[ctrl_word.chan] <= ctrl_word.fmt_serial;
			end
		end
	end

	mbp_buf_ram #(
		.WIDTH(WORD_W),
		.DEPTH(BUF_WORDS)
	) u_ctrl_buf (
		.clk(clk),
		.reset_n(reset_n),
		.we(rx_ctrl),
		.waddr(ctrl_ptr_reg),
		.wdata(bus_rx.data),
		.raddr(ctrl_ptr_reg),
		.rdata()
	);

	// Busy crosses from channel logic through two stages
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			busy_meta_reg <= '0;
			busy_sync_reg <= '0;
		end else begin
			busy_meta_reg <= usr_busy;
			busy_sync_reg <= busy_meta_reg;
		end
	end

	// Same next value feeds both lines so they never overlap
	assign inhibit_next = busy_sync_reg[dest_reg];
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			poll_q_reg <= 1'h0;
			ack_reg <= 1'h0;
			inhibit_reg <= 1'h1;
			intr_reg <= 1'h0;
		end else begin
			poll_q_reg <= bmc_poll;
			inhibit_reg <= inhibit_next;
			intr_reg <= (|ch_pend) && !inhibit_next &&
				state_reg == P_IDLE;
			if (state_reg == P_CHECK && bus_rx.valid) begin
				ack_reg <= rx_accept_reg &&
					bus_rx.data[CRC_W-1:0] == crc_reg;
			end else if (poll_rise) begin
				ack_reg <= 1'h0;
			end
		end
	end

	for (genvar i = 0; i < NUM_CH; i++) begin : g_ch
		if (CH_FITTED[i]) begin : g_fit
			mbp_chan_e st_reg;
			logic [CNT_W-1:0] ptr_reg;
			logic [CNT_W-1:0] cnt_reg;
			logic inflight_reg;
			logic out_valid_reg;
			logic in_ready_reg;
			logic busy_reg;
			logic [WORD_W-1:0] word_reg;
			logic [WORD_W-1:0] out_data_reg;
			logic [BITS_W-1:0] bits_reg;
			logic bus_we;
			logic fill_we;
			logic fill_end;
			logic rd_issue;
			logic out_take;
			logic claim;
			logic [ADDR_W-1:0] raddr;
			logic [ADDR_W-1:0] waddr;
			logic [WORD_W-1:0] wdata;

			assign claim = (state_reg == P_RECV || state_reg == P_CHECK) &&
				dest_reg == CH_W'(i);
			assign bus_we = rx_data && rx_ok && dest_reg == CH_W'(i);
			assign fill_we = usr_in_valid[i] && in_ready_reg;
			assign fill_end = fill_we &&
				(usr_in_last[i] || ptr_reg == FULL_CNT - CNT_W'(1));
			assign out_take = !out_valid_reg || usr_out_ready[i];
			assign rd_issue = st_reg == C_DRAIN && !inflight_reg &&
				bits_reg == '0 && ptr_reg != FULL_CNT;
			assign waddr = bus_we ? rx_cnt_reg[ADDR_W-1:0] :
				ptr_reg[ADDR_W-1:0];
			assign wdata = bus_we ? bus_rx.data : usr_in_data[i];
			// Drain owns the read port; bus send only reads pending channels
			assign raddr = (st_reg == C_DRAIN) ? ptr_reg[ADDR_W-1:0] :
				tx_ptr_reg[ADDR_W-1:0];

			mbp_buf_ram #(
				.WIDTH(WORD_W),
				.DEPTH(BUF_WORDS)
			) u_buf (
				.clk(clk),
				.reset_n(reset_n),
				.we(bus_we || fill_we),
				.waddr(waddr),
				.wdata(wdata),
				.raddr(raddr),
				.rdata(ch_rdata[i])
			);

			assign usr_fire[i] = fill_we;
			assign ch_idle[i] = st_reg == C_IDLE;
			assign ch_pend[i] = st_reg == C_PEND;
			assign ch_cnt[i] = cnt_reg;
			assign usr_busy[i] = busy_reg;
			assign usr_in_ready[i] = in_ready_reg;
			assign usr_out_valid[i] = out_valid_reg;
			assign usr_out_data[i] = out_data_reg;
			assign usr_serial[i] = fmt_reg[i];

			always_ff @(posedge clk or negedge reset_n) begin
				if (!reset_n) begin
					st_reg <= C_IDLE;
					ptr_reg <= '0;
					cnt_reg <= '0;
					inflight_reg <= 1'h0;
					busy_reg <= 1'h0;
					in_ready_reg <= 1'h0;
				end else begin
					inflight_reg <= rd_issue;
					in_ready_reg <= (st_reg == C_IDLE || st_reg == C_FILL) &&
						!claim && !rx_good_reg[i] && !fill_end;
					unique case (st_reg)
						C_IDLE: begin
							if (rx_good_reg[i]) begin
								st_reg <= C_DRAIN;
								ptr_reg <= '0;
								busy_reg <= 1'h1;
							end else if (fill_we) begin
								ptr_reg <= CNT_W'(1);
								cnt_reg <= CNT_W'(1);
								st_reg <= fill_end ? C_PEND : C_FILL;
								busy_reg <= !fill_end;
							end
						end
						C_FILL: begin
							if (fill_we) begin
								ptr_reg <= ptr_reg + CNT_W'(1);
								cnt_reg <= ptr_reg + CNT_W'(1);
								if (fill_end) begin
									st_reg <= C_PEND;
									busy_reg <= 1'h0;
								end
							end
						end
						C_PEND: begin
							if (send_done_reg[i]) begin
								st_reg <= C_IDLE;
								ptr_reg <= '0;
							end
						end
						C_DRAIN: begin
							if (rd_issue) begin
								ptr_reg <= ptr_reg + CNT_W'(1);
							end
							if (ptr_reg == FULL_CNT && !inflight_reg &&
								bits_reg == '0 && out_take) begin
								st_reg <= C_IDLE;
								busy_reg <= 1'h0;
							end
						end
					endcase
				end
			end

			// Serial sends LSB first on bit 0, one beat per bit
			always_ff @(posedge clk or negedge reset_n) begin
				if (!reset_n) begin
					out_valid_reg <= 1'h0;
					out_data_reg <= '0;
					word_reg <= '0;
					bits_reg <= '0;
				end else begin
					if (inflight_reg) begin
						word_reg <= ch_rdata[i];
						bits_reg <= fmt_reg[i] ? SER_BITS : PAR_BITS;
					end else if (bits_reg != '0 && out_take) begin
						word_reg <= word_reg >> 1;
						bits_reg <= bits_reg - BITS_W'(1);
					end
					if (!inflight_reg && bits_reg != '0 && out_take) begin
						out_valid_reg <= 1'h1;
						out_data_reg <= fmt_reg[i] ?
							{{(WORD_W - 1){1'h0}}, word_reg[0]} : word_reg;
					end else if (usr_out_ready[i]) begin
						out_valid_reg <= 1'h0;
					end
				end
			end
		end else begin : g_abs
			assign ch_rdata[i] = '0;
			assign usr_fire[i] = 1'h0;
			assign ch_idle[i] = 1'h0;
			assign ch_pend[i] = 1'h0;
			assign ch_cnt[i] = '0;
			assign usr_busy[i] = 1'h0;
			assign usr_in_ready[i] = 1'h0;
			assign usr_out_valid[i] = 1'h0;
			assign usr_out_data[i] = '0;
			assign usr_serial[i] = fmt_reg[i];
		end
	end

	assign bmc_inhibit = inhibit_reg;
	assign bmc_ack = ack_reg;
	assign bmc_intr = intr_reg;
	assign bus_tx_valid = tx_valid_reg;
	assign bus_tx_data = tx_data_reg;
endmodule

/* File: core/mbp_pkg.sv */
package mbp_pkg;
	localparam int NUM_CH = 8;
	localparam int CH_W = 3;
	localparam int WORD_W = 32;
	localparam int BUF_BITS = 2048;
	localparam int BUF_WORDS = BUF_BITS / WORD_W;
	localparam int ADDR_W = $clog2(BUF_WORDS);
	localparam int CNT_W = ADDR_W + 1;
	localparam int BITS_W = $clog2(WORD_W) + 1;
	localparam int CRC_W = 8;
	localparam logic [CRC_W-1:0] CRC_POLY = 8'h07;
	localparam logic [CRC_W-1:0] CRC_INIT = 8'h00;
	localparam logic [NUM_CH-1:0] CH_FITTED_INIT = 8'h03;
	localparam logic [1:0] CMD_SELECT = 2'h1;
	localparam logic [CNT_W-1:0] FULL_CNT = CNT_W'(BUF_WORDS);
	localparam logic [BITS_W-1:0] SER_BITS = BITS_W'(WORD_W);
	localparam logic [BITS_W-1:0] PAR_BITS = BITS_W'(1);

	typedef struct packed {
		logic [21:0] spare;
		logic fmt_serial;
		logic [1:0] cmd;
		logic [3:0] spare_b;
		logic [CH_W-1:0] chan;
	} mbp_ctrl_word_s;

	typedef struct packed {
		logic valid;
		logic ctrl;
		logic [WORD_W-1:0] data;
	} mbp_bus_word_s;

	typedef enum logic [2:0] {
		P_IDLE = 3'h0,
		P_RECV = 3'h1,
		P_CHECK = 3'h3,
		P_SEND = 3'h2,
		P_SCRC = 3'h6
	} mbp_port_e;

	typedef enum logic [1:0] {
		C_IDLE = 2'h0,
		C_DRAIN = 2'h1,
		C_FILL = 2'h2,
		C_PEND = 2'h3
	} mbp_chan_e;

	// MSB first, one word per call
	function automatic logic [CRC_W-1:0] mbp_crc8(
		input logic [CRC_W-1:0] crc,
		input logic [WORD_W-1:0] word
	);
		logic [CRC_W-1:0] c;
		c = crc;
		for (int k = WORD_W - 1; k >= 0; k--) begin
			if (c[CRC_W-1] ^ word[k]) begin
				c = {c[CRC_W-2:0], 1'h0} ^ CRC_POLY;
			end else begin
				c = {c[CRC_W-2:0], 1'h0};
			end
		end
		return c;
	endfunction
endpackage

/* File: core/mbp_buf_ram.sv */
`timescale 1ns/100ps
module mbp_buf_ram #(
	parameter int WIDTH = 32,
	parameter int DEPTH = 64,
	parameter int AW = $clog2(DEPTH)
) (
	// Clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// Write port
	input wire logic we,
	input wire logic [AW-1:0] waddr,
	input wire logic [WIDTH-1:0] wdata,
	// Read port, one cycle latency
	input wire logic [AW-1:0] raddr,
	output logic [WIDTH-1:0] rdata
);
	logic [WIDTH-1:0] mem [DEPTH];

	always_ff @(posedge clk) begin
		if (we) begin
			mem[waddr] <= wdata;
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			rdata <= '0;
		end else begin
			rdata <= mem[raddr];
		end
	end
endmodule

/* File: bench/mbp_checker.sv */
`timescale 1ns/100ps
module mbp_checker import mbp_pkg::*; #(
	parameter logic [NUM_CH-1:0] CH_FITTED = CH_FITTED_INIT
) (
	// Clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// Bus master controller lines
	input wire logic bmc_poll,
	input wire logic bmc_inhibit,
	input wire logic bmc_ack,
	input wire logic bmc_intr,
	// Shared bus
	input wire mbp_bus_word_s bus_rx,
	input wire logic bus_tx_valid,
	// Channel status
	input wire logic [NUM_CH-1:0] usr_out_valid,
	input wire logic [NUM_CH-1:0] usr_in_ready,
	input wire logic [NUM_CH-1:0] usr_busy
);
	mbp_ctrl_word_s cw;
	logic [CH_W-1:0] dest_reg;
	assign cw = bus_rx.data;
	// Own copy of the selected channel, not the design's
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n)
			dest_reg <= '0;
		else if (bus_rx.valid && bus_rx.ctrl && cw.cmd == CMD_SELECT)
			dest_reg <= cw.chan;
	end
	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);
	intr_no_inhibit_a: assert property (bmc_intr |-> !bmc_inhibit)
		else $error("interrupt raised with inhibit");
	busy_inhibit_a: assert property (
		(usr_busy[dest_reg] && $stable(dest_reg)) [*4] |-> bmc_inhibit)
		else $error("busy channel without inhibit");
	ack_cause_a: assert property ($rose(bmc_ack) |->
		$past(bus_rx.valid) || $past(bus_rx.valid, 2))
		else $error("acknowledge without a received word");
	ack_clear_a: assert property ($fell(bmc_ack) |->
		$past(bmc_poll) && !$past(bmc_poll, 2))
		else $error("acknowledge dropped without poll");
	drain_start_a: assert property (
		$rose(bmc_ack) |-> ##[0:2] usr_busy[dest_reg])
		else $error("good block not routed to channel");
	absent_quiet_a: assert property (
		((usr_busy | usr_out_valid | usr_in_ready) & ~CH_FITTED) == '0)
		else $error("absent channel active");
	out_busy_a: assert property ((usr_out_valid & ~usr_busy) == '0)
		else $error("user output while not busy");
	fill_idle_a: assert property (
		(usr_in_ready & usr_out_valid) == '0)
		else $error("user input taken while draining");
	send_start_a: assert property (
		$rose(bmc_poll) && bmc_intr |-> ##[3:4] bus_tx_valid)
		else $error("send did not start after poll");
	recv_quiet_a: assert property (
		$rose(bmc_poll) && !bmc_intr |=> !bus_tx_valid [*4])
		else $error("port sent on a receive poll");
endmodule
bind mbp_port_top mbp_checker #(.CH_FITTED(CH_FITTED)) u_mbp_checker (
	.clk(clk), .reset_n(reset_n), .bmc_poll(bmc_poll),
	.bmc_inhibit(bmc_inhibit), .bmc_ack(bmc_ack), .bmc_intr(bmc_intr),
	.bus_rx(bus_rx), .bus_tx_valid(bus_tx_valid),
	.usr_out_valid(usr_out_valid), .usr_in_ready(usr_in_ready),
	.usr_busy(usr_busy));

/* File: bench/mbp_bmc_model.sv */
`timescale 1ns/100ps
module mbp_bmc_model import mbp_pkg::*; (
	// Clock
	input wire logic clk,
	// Port status
	input wire logic bmc_intr,
	// Toward the port
	output logic bmc_poll,
	output mbp_bus_word_s bus_rx
);
	initial begin
		bmc_poll = 1'h0;
		bus_rx = '0;
	end
	task automatic poll(logic up);
		bmc_poll = up;
		repeat (2) @(posedge clk);
		#1;
	endtask
	task automatic word(logic ctl, logic [WORD_W-1:0] d, int gap);
		bus_rx = '{1'h1, ctl, d};
		@(posedge clk);
		#1;
		// Back to back words keep valid up, no zero-time glitch
		if (gap > 0) begin
			// Released bus must not look like a held word
			bus_rx = '{1'h0, 1'h0, ~d};
			#(20 * gap);
		end
	endtask
	task automatic fetch(int cycles);
		wait (bmc_intr === 1'h1);
		@(posedge clk);
		#1;
		poll(1'h1);
		repeat (cycles) @(posedge clk);
		#1;
		poll(1'h0);
	endtask
endmodule

/* File: bench/testbench.sv */
`timescale 1ns/100ps
module testbench import mbp_pkg::*; ;
	logic clk = 1'h0;
	logic reset_n = 1'h0;
	logic bmc_poll, bmc_inhibit, bmc_ack, bmc_intr, bus_tx_valid;
	mbp_bus_word_s bus_rx;
	logic [WORD_W-1:0] bus_tx_data;
	logic [NUM_CH-1:0] usr_out_valid, usr_in_ready, usr_busy, usr_serial;
	logic [NUM_CH-1:0] usr_out_ready = '0;
	logic [NUM_CH-1:0] usr_in_valid = '0;
	logic [NUM_CH-1:0] usr_in_last = '0;
	logic [NUM_CH-1:0] hold = '0;
	logic [NUM_CH-1:0][WORD_W-1:0] usr_out_data;
	logic [NUM_CH-1:0][WORD_W-1:0] usr_in_data = '0;
	logic [31:0] rng = 32'h0000_000f;
	logic [WORD_W-1:0] exp_q[NUM_CH+1][$];
	int failures = 0;
	int n_compared = 0;

	always #10 clk = ~clk;

	mbp_port_top u_mbp_port_top (.clk(clk), .reset_n(reset_n),
		.bmc_poll(bmc_poll), .bmc_inhibit(bmc_inhibit), .bmc_ack(bmc_ack),
		.bmc_intr(bmc_intr), .bus_rx(bus_rx), .bus_tx_valid(bus_tx_valid),
		.bus_tx_data(bus_tx_data), .usr_out_valid(usr_out_valid),
		.usr_out_data(usr_out_data), .usr_out_ready(usr_out_ready),
		.usr_in_valid(usr_in_valid), .usr_in_data(usr_in_data),
		.usr_in_last(usr_in_last), .usr_in_ready(usr_in_ready),
		.usr_busy(usr_busy), .usr_serial(usr_serial));
	mbp_bmc_model u_mbp_bmc_model (.clk(clk), .bmc_intr(bmc_intr),
		.bmc_poll(bmc_poll), .bus_rx(bus_rx));

	function automatic logic [31:0] rnd();
		rng ^= rng << 13;
		rng ^= rng >> 17;
		rng ^= rng << 5;
		return rng;
	endfunction
	function automatic logic [CRC_W-1:0] crc_w(logic [CRC_W-1:0] c,
		logic [WORD_W-1:0] w);
		for (int k = WORD_W - 1; k >= 0; k--)
			c = {c[CRC_W-2:0], 1'h0} ^ ((c[CRC_W-1] ^ w[k]) ? CRC_POLY : '0);
		return c;
	endfunction
	function automatic logic [WORD_W-1:0] pop(int q);
		return exp_q[q].size() ? exp_q[q].pop_front() : 'x;
	endfunction
	task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			failures++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic wrap_up();
		if (failures == 0 && n_compared > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	// One block from the master; refused blocks leave no expectation
	task automatic recv(int ch, bit ser, bit bad, bit ok, bit inh);
		logic [WORD_W-1:0] w;
		logic [CRC_W-1:0] c;
		c = CRC_INIT;
		w = {22'h00_0000, ser, CMD_SELECT, 4'h0, 3'(ch)};
		u_mbp_bmc_model.poll(1'h1);
		u_mbp_bmc_model.word(1'h1, w, 4);
		// Not a select: its channel and format must be ignored
		u_mbp_bmc_model.word(1'h1, w ^ 32'h0000_0284, 1);
		check("inhibit", bmc_inhibit, inh);
		check("serial", usr_serial[ch], ser);
		for (int i = 0; i < BUF_WORDS; i++) begin
			w = rnd();
			c = crc_w(c, w);
			for (int b = 0; b < WORD_W; b++)
				if (ok && !bad && (ser || b == 0))
					exp_q[ch].push_back(ser ? WORD_W'(w[b]) : w);
			u_mbp_bmc_model.word(1'h0, w, int'(w[0]));
		end
		u_mbp_bmc_model.word(1'h0, {24'h00_0000, c ^ CRC_W'(bad)}, 1);
		repeat (3) @(posedge clk);
		#1;
		check("ack", bmc_ack, ok && !bad);
		check("busy", usr_busy[ch], (ok && !bad) || inh);
		u_mbp_bmc_model.poll(1'h0);
	endtask

	always @(posedge clk) begin
		#1;
		usr_out_ready = NUM_CH'(rnd()) & ~hold;
	end

	always @(posedge clk) begin
		// Serial beats must keep the unused bits low
		for (int c = 0; c < NUM_CH; c++)
			if (usr_out_valid[c] === 1'h1 && usr_out_ready[c] === 1'h1)
				check("user word", usr_out_data[c], pop(c));
		if (bus_tx_valid === 1'h1)
			check("bus word", bus_tx_data, pop(NUM_CH));
	end

	initial begin
		logic [CRC_W-1:0] c;
		c = CRC_INIT;
		repeat (4) @(posedge clk);
		check("inhibit in reset", bmc_inhibit, 1);
		#1;
		reset_n = 1'h1;
		repeat (2) @(posedge clk);
		#1;
		hold[0] = 1'h1;
		recv(0, 0, 0, 1, 0);
		recv(0, 0, 0, 0, 1);
		recv(5, 0, 0, 0, 0);
		recv(1, 1, 1, 0, 0);
		recv(1, 1, 0, 1, 0);
		hold = '0;
		wait (usr_busy === '0);
		@(posedge clk);
		#1;
		// Short user block, sent on the next poll
		for (int i = 0; i < 3; i++) begin
			usr_in_valid[0] = 1'h1;
			usr_in_last[0] = 1'(i == 2);
			usr_in_data[0] = rnd();
			exp_q[NUM_CH].push_back(usr_in_data[0]);
			c = crc_w(c, usr_in_data[0]);
			do @(posedge clk); while (usr_in_ready[0] !== 1'h1);
			#1;
		end
		usr_in_valid[0] = 1'h0;
		exp_q[NUM_CH].push_back({24'h00_0000, c});
		check("ack held", bmc_ack, 1);
		u_mbp_bmc_model.fetch(12);
		check("ack cleared", bmc_ack, 0);
		check("intr", bmc_intr, 0);
		for (int q = 0; q <= NUM_CH; q++)
			check("left over", exp_q[q].size(), 0);
		wrap_up();
	end

	initial begin
		repeat (60000) @(posedge clk);
		failures++;
		wrap_up();
	end
endmodule
